// ==== filter_cfg_pkg.sv ====
`default_nettype none
package filter_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // serial word layout
    localparam int         WORD_W       = 8;
    localparam int         HOLD_W       = 6;
    localparam int         SEL_HI       = 7;
    localparam int         SEL_LO       = 6;
    localparam logic [3:0] WORD_BITS    = 4'h8;
    localparam logic [3:0] BIT_CNT_MAX  = 4'hf;

    // holding register select codes
    localparam logic [1:0] SEL_FREQ_A   = 2'h0;
    localparam logic [1:0] SEL_FREQ_B   = 2'h1;
    localparam logic [1:0] SEL_NONE     = 2'h2;
    localparam logic [1:0] SEL_GAIN     = 2'h3;

    // field positions inside the holding registers
    localparam int         FA_STEP_HI   = 5;
    localparam int         FA_STEP_LO   = 3;
    localparam int         FA_CHORD_HI  = 2;
    localparam int         FA_CHORD_LO  = 0;
    localparam int         FB_OSC       = 5;
    localparam int         FB_STEP_HI   = 3;
    localparam int         FB_STEP_LO   = 0;

    // cutoff and gain coding
    localparam int         CHORD_W      = 3;
    localparam int         STEP_W       = 7;
    localparam int         CUTOFF_W     = 12;
    localparam logic [2:0] CHORD_TOP    = 3'h4;
    localparam logic [5:0] FINE_PER_CRS = 6'h6;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte offsets on the bus
    localparam int         REG_ADDR_W   = 8;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_FREQ_A   = 8'h08;
    localparam logic [7:0] OFF_FREQ_B   = 8'h0c;
    localparam logic [7:0] OFF_GAIN     = 8'h10;
    localparam logic [7:0] OFF_CUTOFF   = 8'h14;
    localparam logic [7:0] OFF_GAIN_SPL = 8'h18;
    localparam logic [7:0] OFF_WORDS    = 8'h1c;

    // control and status bits
    localparam int         CTRL_PORT_ON = 0;
    localparam logic       PORT_ON_RST  = 1'b1;
    localparam int         ST_WRITTEN   = 0;
    localparam int         ST_IGNORED   = 3;
    localparam int         ST_SHORT     = 4;
    localparam int         ST_LONG      = 5;
    localparam int         ST_W         = 6;
    localparam int         WORDS_W      = 16;
    localparam int         GS_CRS_LO    = 4;

    typedef enum logic {
        FRAME_IDLE  = 1'b0,
        FRAME_SHIFT = 1'b1
    } frame_state_t;

endpackage
`default_nettype wire

// ==== hold_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface hold_if;
    logic       load;
    logic [7:0] word;
    logic       frame_short;
    logic       frame_long;
    logic [5:0] freq_a;
    logic [5:0] freq_b;
    logic [5:0] gain;
    logic [2:0] written;
    logic       ignored;

    modport cap  (output load, word, frame_short, frame_long);
    modport bank (input load, word, output freq_a, freq_b, gain, written, ignored);
    modport top  (input frame_short, frame_long, freq_a, freq_b, gain, written, ignored);
endinterface
`default_nettype wire

// ==== serial_capture.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_capture
    import filter_cfg_pkg::*;
(
    // system
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic port_on_i,
    // link pins
    input  wire logic serial_load_enable_i,
    input  wire logic shift_clock_i,
    input  wire logic serial_in_line_i,
    // towards the holding bank
    hold_if.cap       hif
);
    logic [2:0]   en_sync;
    logic [2:0]   sck_sync;
    logic [2:0]   dat_sync;
    logic [7:0]   shift_in_register;
    logic [3:0]   bit_cnt;
    frame_state_t frame_state;
    logic         sck_rise;
    logic         en_fall;

    ////////////////////////////////////////////////////////////////////////
    // stage 0 feeds stage 1 only; stage 2 is a delayed copy
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            en_sync  <= 3'h0;
            sck_sync <= 3'h0;
            dat_sync <= 3'h0;
        end else begin
            en_sync  <= {en_sync[1:0], serial_load_enable_i};
            sck_sync <= {sck_sync[1:0], shift_clock_i};
            dat_sync <= {dat_sync[1:0], serial_in_line_i};
        end
    end

    // data taken one sample before the seen edge, where it had its setup
    assign sck_rise = sck_sync[1] & ~sck_sync[2];
    assign en_fall  = ~en_sync[1] & en_sync[2];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            frame_state <= FRAME_IDLE;
        end else begin
            case (frame_state)
                FRAME_IDLE: begin
                    if (en_sync[1] && port_on_i) begin
                        frame_state <= FRAME_SHIFT;
                    end
                end
                FRAME_SHIFT: begin
                    if (!en_sync[1]) begin
                        frame_state <= FRAME_IDLE;
                    end
                end
                default: frame_state <= FRAME_IDLE;
            endcase
        end
    end

    // no power-on clear, as in the original port
    always_ff @(posedge clk_sys_i) begin
        if (sck_rise && en_sync[1] && frame_state == FRAME_SHIFT) begin
            shift_in_register <= {shift_in_register[6:0], dat_sync[2]};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || frame_state == FRAME_IDLE) begin
            bit_cnt <= 4'h0;
        end else if (sck_rise && en_sync[1] && bit_cnt != BIT_CNT_MAX) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hif.load        <= 1'b0;
            hif.frame_short <= 1'b0;
            hif.frame_long  <= 1'b0;
        end else begin
            hif.load        <= en_fall && frame_state == FRAME_SHIFT;
            hif.frame_short <= en_fall && frame_state == FRAME_SHIFT
                               && bit_cnt < WORD_BITS;
            hif.frame_long  <= en_fall && frame_state == FRAME_SHIFT
                               && bit_cnt > WORD_BITS;
        end
    end

    assign hif.word = shift_in_register;

endmodule
`default_nettype wire

// ==== holding_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module holding_bank
    import filter_cfg_pkg::*;
(
    // system
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // word in, registers out
    hold_if.bank      hif
);
    logic [1:0] sel;

    assign sel = hif.word[SEL_HI:SEL_LO];

    ////////////////////////////////////////////////////////////////////////
    // data registers keep no reset: contents are undefined until written
    always_ff @(posedge clk_sys_i) begin
        if (hif.load) begin
            case (sel)
                SEL_FREQ_A: hif.freq_a <= hif.word[HOLD_W-1:0];
                SEL_FREQ_B: hif.freq_b <= hif.word[HOLD_W-1:0];
                SEL_GAIN:   hif.gain   <= hif.word[HOLD_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hif.written <= 3'h0;
            hif.ignored <= 1'b0;
        end else begin
            hif.ignored <= hif.load && sel == SEL_NONE;
            if (hif.load && sel != SEL_NONE) begin
                hif.written[sel == SEL_GAIN ? 2'h2 : sel] <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ==== three_wire_filter_config_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module three_wire_filter_config_port
    import filter_cfg_pkg::*;
(
    // system
    input  wire logic                               clk_sys_i,
    input  wire logic                               rst_i,
    // three-wire link
    input  wire logic                               serial_load_enable_i,
    input  wire logic                               shift_clock_i,
    input  wire logic                               serial_in_line_i,
    // ahb-lite slave
    input  wire logic                               hsel_i,
    input  wire logic [31:0]                        haddr_i,
    input  wire logic [1:0]                         htrans_i,
    input  wire logic                               hwrite_i,
    input  wire logic [2:0]                         hsize_i,
    input  wire logic [31:0]                        hwdata_i,
    input  wire logic                               hready_i,
    output logic      [31:0]                        hrdata_o,
    output logic                                    hreadyout_o,
    output logic                                    hresp_o,
    // filter settings
    output logic      [filter_cfg_pkg::CHORD_W-1:0] chord_select_o,
    output logic      [filter_cfg_pkg::STEP_W-1:0]  step_select_o,
    output logic                                    osc_test_on_o,
    output logic      [filter_cfg_pkg::HOLD_W-1:0]  gain_code_o,
    output logic      [2:0]                         gain_fine_o,
    output logic      [3:0]                         gain_coarse_o,
    output logic      [filter_cfg_pkg::CUTOFF_W-1:0] cutoff_units_o,
    output logic                                    settings_valid_o
);
    import filter_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // five chords: codes 1xx share the top chord
    function automatic logic [2:0] chord_index(input logic [CHORD_W-1:0] c);
        if (c[CHORD_W-1]) begin
            chord_index = CHORD_TOP;
        end else begin
            chord_index = c;
        end
    endfunction

    // cutoff in units of the lowest step: (128 + n) scaled per chord
    function automatic logic [CUTOFF_W-1:0] cutoff_units(input logic [CHORD_W-1:0] c,
                                                         input logic [STEP_W-1:0]  s);
        logic [CUTOFF_W-1:0] base;
        base = {4'h0, 1'b1, s};
        cutoff_units = base << chord_index(c);
    endfunction

    function automatic logic [STEP_W-1:0] step_of(input logic [HOLD_W-1:0] a,
                                                  input logic [HOLD_W-1:0] b);
        step_of = {b[FB_STEP_HI:FB_STEP_LO], a[FA_STEP_HI:FA_STEP_LO]};
    endfunction

    function automatic logic [31:0] zext(input logic [WORDS_W-1:0] v);
        zext = {16'h0000, v};
    endfunction

    // one decoder for every register read
    function automatic logic addr_is(input logic [31:0] a, input logic [REG_ADDR_W-1:0] off);
        addr_is = a[REG_ADDR_W-1:0] == off;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // submodules
    hold_if hif ();

    logic port_on;

    serial_capture u_capture (
        .clk_sys_i            (clk_sys_i),
        .rst_i                (rst_i),
        .port_on_i            (port_on),
        .serial_load_enable_i (serial_load_enable_i),
        .shift_clock_i        (shift_clock_i),
        .serial_in_line_i     (serial_in_line_i),
        .hif                  (hif.cap)
    );

    holding_bank u_bank (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .hif       (hif.bank)
    );

    ////////////////////////////////////////////////////////////////////////
    // derived settings
    logic [CHORD_W-1:0]  chord_now;
    logic [STEP_W-1:0]   step_now;
    logic [CUTOFF_W-1:0] cutoff_now;
    logic [2:0]          fine_now;
    logic [3:0]          coarse_now;

    assign chord_now  = hif.freq_a[FA_CHORD_HI:FA_CHORD_LO];
    assign step_now   = step_of(hif.freq_a, hif.freq_b);
    assign cutoff_now = cutoff_units(chord_now, step_now);
    // one coarse step is six fine steps
    assign coarse_now = 4'(hif.gain / FINE_PER_CRS);
    assign fine_now   = 3'(hif.gain % FINE_PER_CRS);

    // outputs follow a register only once it has been written
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            chord_select_o <= '0;
            step_select_o  <= '0;
            osc_test_on_o  <= 1'b0;
        end else begin
            if (hif.written[0]) begin
                chord_select_o                 <= chord_now;
                step_select_o[FA_STEP_HI-FA_STEP_LO:0] <= step_now[2:0];
            end
            if (hif.written[1]) begin
                step_select_o[STEP_W-1:3] <= step_now[STEP_W-1:3];
                // bit 4 of this register carries nothing
                osc_test_on_o             <= hif.freq_b[FB_OSC];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            gain_code_o   <= '0;
            gain_fine_o   <= 3'h0;
            gain_coarse_o <= 4'h0;
        end else if (hif.written[2]) begin
            gain_code_o   <= hif.gain;
            gain_fine_o   <= fine_now;
            gain_coarse_o <= coarse_now;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cutoff_units_o <= '0;
        end else if (hif.written[1:0] == 2'h3) begin
            cutoff_units_o <= cutoff_now;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            settings_valid_o <= 1'b0;
        end else begin
            settings_valid_o <= &hif.written;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait states, always okay
    logic                  take;
    logic                  wr_pend;
    logic [REG_ADDR_W-1:0] wr_addr;
    logic                  wr_ctrl;
    logic                  wr_status;
    logic [31:0]           rd_value;
    logic [ST_W-1:0]       status;
    logic                  ignored_flag;
    logic                  short_flag;
    logic                  long_flag;
    logic [WORDS_W-1:0]    word_count;

    assign take = hsel_i & htrans_i[1] & hready_i;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= take & hwrite_i;
            if (take) begin
                wr_addr <= haddr_i[REG_ADDR_W-1:0];
            end
        end
    end

    assign wr_ctrl   = wr_pend && wr_addr == OFF_CTRL;
    assign wr_status = wr_pend && wr_addr == OFF_STATUS;

    // upper address bits are not decoded; the map repeats
    always_comb begin
        rd_value = 32'h0000_0000;
        if (addr_is(haddr_i, OFF_CTRL)) begin
            rd_value[CTRL_PORT_ON] = port_on;
        end else if (addr_is(haddr_i, OFF_STATUS)) begin
            rd_value[ST_W-1:0] = status;
        end else if (addr_is(haddr_i, OFF_FREQ_A)) begin
            rd_value[HOLD_W-1:0] = hif.written[0] ? hif.freq_a : '0;
        end else if (addr_is(haddr_i, OFF_FREQ_B)) begin
            rd_value[HOLD_W-1:0] = hif.written[1] ? hif.freq_b : '0;
        end else if (addr_is(haddr_i, OFF_GAIN)) begin
            rd_value[HOLD_W-1:0] = hif.written[2] ? hif.gain : '0;
        end else if (addr_is(haddr_i, OFF_CUTOFF)) begin
            rd_value[CUTOFF_W-1:0] = cutoff_units_o;
        end else if (addr_is(haddr_i, OFF_GAIN_SPL)) begin
            rd_value[GS_CRS_LO+3:GS_CRS_LO] = gain_coarse_o;
            rd_value[2:0]                   = gain_fine_o;
        end else if (addr_is(haddr_i, OFF_WORDS)) begin
            rd_value = zext(word_count);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (take && !hwrite_i) begin
            hrdata_o <= rd_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control: port off keeps frames from starting; switched on mid-frame, the rest of that frame is loaded; a frame already begun finishes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            port_on <= PORT_ON_RST;
        end else if (wr_ctrl) begin
            port_on <= hwdata_i[CTRL_PORT_ON];
        end
    end

    // written flags live in the bank; the error flags are sticky,
    // cleared by writing one, and a new event beats the clear
    function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
        if (set) begin
            sticky_next = 1'b1;
        end else if (clr) begin
            sticky_next = 1'b0;
        end else begin
            sticky_next = cur;
        end
    endfunction

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ignored_flag <= 1'b0;
        end else begin
            ignored_flag <= sticky_next(ignored_flag, hif.ignored,
                                        wr_status && hwdata_i[ST_IGNORED]);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            short_flag <= 1'b0;
        end else begin
            short_flag <= sticky_next(short_flag, hif.frame_short,
                                      wr_status && hwdata_i[ST_SHORT]);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            long_flag <= 1'b0;
        end else begin
            long_flag <= sticky_next(long_flag, hif.frame_long,
                                     wr_status && hwdata_i[ST_LONG]);
        end
    end

    assign status = {long_flag, short_flag, ignored_flag, hif.written};

    // counts every loaded frame, including one whose port was switched on mid-frame, wrapping
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            word_count <= '0;
        end else if (hif.load) begin
            word_count <= word_count + 16'h0001;
        end
    end

endmodule
`default_nettype wire

// ==== filter_cfg_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module filter_cfg_monitor
    import filter_cfg_pkg::*;
(
    // system
    input wire logic                                clk_sys_i,
    input wire logic                                rst_i,
    // link and bus
    input wire logic                                serial_load_enable_i,
    input wire logic                                hreadyout_o,
    input wire logic                                hresp_o,
    // settings
    input wire logic [filter_cfg_pkg::CHORD_W-1:0]  chord_select_o,
    input wire logic [filter_cfg_pkg::STEP_W-1:0]   step_select_o,
    input wire logic                                osc_test_on_o,
    input wire logic [filter_cfg_pkg::HOLD_W-1:0]   gain_code_o,
    input wire logic [2:0]                          gain_fine_o,
    input wire logic [3:0]                          gain_coarse_o,
    input wire logic [filter_cfg_pkg::CUTOFF_W-1:0] cutoff_units_o,
    input wire logic                                settings_valid_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    wire logic [17:0] settings;
    wire logic [2:0]  chord_idx;
    wire logic [11:0] cut_exp;
    assign settings  = {chord_select_o, step_select_o, osc_test_on_o, gain_code_o,
                        settings_valid_o};
    // chords 1xx share the top octave
    assign chord_idx = chord_select_o[2] ? CHORD_TOP : chord_select_o;
    assign cut_exp   = 12'({1'b1, step_select_o}) << chord_idx;
    sequence s_frame_open;
        serial_load_enable_i [*8];
    endsequence
    sequence s_link_quiet;
        !serial_load_enable_i [*8];
    endsequence
    sequence s_gain_settled;
        $stable(gain_code_o) [*3];
    endsequence
    sequence s_freq_settled;
        $stable({chord_select_o, step_select_o}) [*3];
    endsequence
    ////////////////////////////////////////////////////////////
    // eight cycles covers the two-flop sync plus load latency
    a_hold_in_frame: assert property (s_frame_open |-> $stable(settings))
        else $error("settings moved while frame open");
    a_hold_when_quiet: assert property (s_link_quiet |-> $stable(settings))
        else $error("settings moved on idle link");
    a_valid_sticky: assert property (settings_valid_o |=> settings_valid_o)
        else $error("settings valid dropped");
    a_load_after_fall: assert property ($rose(settings_valid_o) |->
        $past(serial_load_enable_i, 3) == 1'b0)
        else $error("load without enable fall");
    a_fine_split: assert property (s_gain_settled |->
        gain_fine_o == 3'(gain_code_o % FINE_PER_CRS))
        else $error("fine gain mismatch");
    a_coarse_split: assert property (s_gain_settled |->
        gain_coarse_o == 4'(gain_code_o / FINE_PER_CRS))
        else $error("coarse gain mismatch");
    a_cutoff_law: assert property (s_freq_settled ##0 (cutoff_units_o != 12'h0) |->
        cutoff_units_o == cut_exp)
        else $error("cutoff law mismatch");
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or error response");
endmodule
`default_nettype wire

// ==== host_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    // link pins
    output logic serial_load_enable_o,
    output logic shift_clock_o,
    output logic serial_in_line_o
);
    localparam time HALF = 200ns;
    initial begin
        serial_load_enable_o = 1'b0;
        shift_clock_o        = 1'b0;
        serial_in_line_o     = 1'b0;
    end
    // one whole word per frame, clock stands still between frames
    task automatic send(input logic [7:0] w);
        int i;
        #7;
        serial_load_enable_o = 1'b1;
        for (i = 7; i >= 0; i--) begin
            serial_in_line_o = w[i];
            #HALF;
            shift_clock_o = 1'b1;
            #HALF;
            shift_clock_o = 1'b0;
        end
        #HALF;
        serial_load_enable_o = 1'b0;
        // released line shows the inverse, not a stale bit
        serial_in_line_o = ~w[0];
        #(4*HALF);
    endtask
endmodule
`default_nettype wire

// ==== tb_three_wire_filter_config_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_three_wire_filter_config_port;
    import filter_cfg_pkg::*;
    logic        clk_sys_i, rst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    logic [1:0]  htrans_i, sel;
    logic [2:0]  hsize_i, chord_select_o, gain_fine_o;
    logic [6:0]  step_select_o;
    logic [5:0]  gain_code_o, ra, rb, rg, d;
    logic [3:0]  gain_coarse_o;
    logic [11:0] cutoff_units_o;
    logic [15:0] seed = 16'h36e6;
    logic        osc_test_on_o, settings_valid_o, wa, wb, wg;
    wire logic   en, sck, sdi;
    logic [1:0]  first [5];
    int          n_errors, compares, k;
    assign hready_i = hreadyout_o;
    ////////////////////////////////////////////////////////////
    three_wire_filter_config_port DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .serial_load_enable_i(en), .shift_clock_i(sck), .serial_in_line_i(sdi),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .chord_select_o(chord_select_o),
        .step_select_o(step_select_o), .osc_test_on_o(osc_test_on_o),
        .gain_code_o(gain_code_o), .gain_fine_o(gain_fine_o), .gain_coarse_o(gain_coarse_o),
        .cutoff_units_o(cutoff_units_o), .settings_valid_o(settings_valid_o));
    host_link_model u_host (.serial_load_enable_o(en), .shift_clock_o(sck),
        .serial_in_line_o(sdi));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // single word transfer, waits on hready with a bound
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int t;
        hsel_i <= 1'b1; haddr_i <= {24'h0, a}; htrans_i <= 2'h2; hwrite_i <= wr;
        hsize_i <= 3'h2;
        t = 0;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1 && ++t < 100);
        htrans_i <= 2'h0; hwdata_i <= wd;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1 && ++t < 100);
        rd = hrdata_o;
        if (t >= 100) n_errors++;
    endtask
    task automatic compare_all();
        logic [5:0] g;
        logic [2:0] ci;
        @(negedge clk_sys_i);
        g  = wg ? rg : 6'h0;
        ci = ra[2] ? 3'h4 : ra[2:0];
        check("chord", chord_select_o, wa ? ra[2:0] : 3'h0);
        check("step", step_select_o, {wb ? rb[3:0] : 4'h0, wa ? ra[5:3] : 3'h0});
        check("osc", osc_test_on_o, wb & rb[5]);
        check("gain", gain_code_o, g);
        check("fine", gain_fine_o, g % FINE_PER_CRS);
        check("coarse", gain_coarse_o, g / FINE_PER_CRS);
        check("cutoff", cutoff_units_o, (wa & wb) ? {1'b1, rb[3:0], ra[5:3]} << ci : 32'h0);
        check("valid", settings_valid_o, wa & wb & wg);
        @(posedge clk_sys_i);
    endtask
    task automatic frame(input logic [1:0] s, input logic [5:0] v, input logic on);
        u_host.send({s, v});
        if (on && s == SEL_FREQ_A) begin ra = v; wa = 1'b1; end
        if (on && s == SEL_FREQ_B) begin rb = v; wb = 1'b1; end
        if (on && s == SEL_GAIN) begin rg = v; wg = 1'b1; end
        @(posedge clk_sys_i);
        compare_all();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #1ms;
        n_errors++;
        stop_test();
    end
    initial begin
        {hsel_i, hwrite_i, htrans_i, haddr_i, hsize_i, hwdata_i} = '0;
        {wa, wb, wg, ra, rb, rg} = '0;
        first = '{SEL_FREQ_A, SEL_FREQ_B, SEL_NONE, SEL_GAIN, SEL_FREQ_A};
        rst_i = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        compare_all();
        bus(1'b0, OFF_STATUS, 32'h0);
        check("status", rd, 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        check("unmapped", rd, 32'h0);
        // select 10 before gain: must not count as a gain write
        for (k = 0; k < 24; k++) begin
            seed = lfsr(seed);
            sel = (k < 5) ? first[k] : seed[7:6];
            d = (k == 4) ? 6'h3f : seed[5:0];
            if (sel == SEL_FREQ_B) d[4] = 1'b0;
            frame(sel, d, 1'b1);
        end
        bus(1'b0, OFF_STATUS, 32'h0);
        check("status", rd, 32'h0000_000f);
        bus(1'b1, OFF_STATUS, 32'h0000_0008);
        bus(1'b0, OFF_STATUS, 32'h0);
        check("status_clr", rd, 32'h0000_0007);
        bus(1'b0, OFF_FREQ_A, 32'h0);
        check("freq_a", rd, {26'h0, ra});
        bus(1'b0, OFF_GAIN, 32'h0);
        check("gain_reg", rd, {26'h0, rg});
        bus(1'b1, OFF_CTRL, 32'h0);
        frame(SEL_GAIN, ~rg, 1'b0);
        bus(1'b1, OFF_CTRL, 32'h1);
        bus(1'b0, OFF_CTRL, 32'h0);
        check("ctrl", rd, 32'h1);
        frame(SEL_GAIN, ~rg, 1'b1);
        stop_test();
    end
endmodule
bind three_wire_filter_config_port filter_cfg_monitor u_mon (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .serial_load_enable_i(serial_load_enable_i), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .chord_select_o(chord_select_o), .step_select_o(step_select_o),
    .osc_test_on_o(osc_test_on_o), .gain_code_o(gain_code_o), .gain_fine_o(gain_fine_o),
    .gain_coarse_o(gain_coarse_o), .cutoff_units_o(cutoff_units_o),
    .settings_valid_o(settings_valid_o));
`default_nettype wire
